// File: common/can_err_pkg.sv
// Purpose: shared constants and types of the CAN error confinement block
// Assumes: protocol engine outside supplies field codes and sample ticks
// Notes: offsets are byte addresses on a 32-bit APB
package can_err_pkg;

   typedef logic [3:0] field_t;
   typedef logic [7:0] addr_t;

   // ***************************************
   // frame field codes from the engine
   // ***************************************
   localparam field_t F_IDLE = 4'h0;
   localparam field_t F_SOF = 4'h1;
   localparam field_t F_ARB = 4'h2;
   localparam field_t F_CTRL = 4'h3;
   localparam field_t F_DATA = 4'h4;
   localparam field_t F_CRC = 4'h5;
   localparam field_t F_CRC_DELIM = 4'h6;
   localparam field_t F_ACK_SLOT = 4'h7;
   localparam field_t F_ACK_DELIM = 4'h8;
   localparam field_t F_EOF = 4'h9;
   localparam field_t F_IFS = 4'ha;
   localparam field_t F_ERR_FRAME = 4'hb;

   // ***************************************
   // register map
   // ***************************************
   localparam addr_t TX_ERR_COUNT_ADDR = 8'h1c;
   localparam addr_t RX_ERR_COUNT_ADDR = 8'h20;
   localparam addr_t ERR_FLAG_ADDR = 8'h24;
   localparam addr_t LAST_ERR_ADDR = 8'h28;
   localparam addr_t CTRL_ADDR = 8'h2c;
   localparam int CTRL_AUTO_REC_BIT = 0;
   localparam logic CTRL_AUTO_REC_RST = 1'b1;

   // ***************************************
   // error codes
   // ***************************************
   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_BIT = 3'h1;
   localparam logic [2:0] ERR_STUFF = 3'h2;
   localparam logic [2:0] ERR_CRC = 3'h3;
   localparam logic [2:0] ERR_FORM = 3'h4;
   localparam logic [2:0] ERR_ACK = 3'h5;

   // ***************************************
   // limits and counts
   // ***************************************
   localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
   localparam logic [8:0] BUSOFF_LIMIT = 9'h100;
   localparam logic [8:0] WARN_LIMIT = 9'h060;
   localparam logic [8:0] TX_ERR_STEP = 9'h008;
   localparam logic [7:0] RX_RESTORE = 8'h7f;
   localparam logic [2:0] STUFF_RUN = 3'h6;
   localparam logic [3:0] RECESSIVE_RUN = 4'hb;
   localparam logic [7:0] RECOVERY_OCCUR = 8'h80;
   localparam logic [14:0] CRC_POLY = 15'h4599;

   typedef enum logic [2:0] {
      MODE_ACTIVE = 3'b001,
      MODE_PASSIVE = 3'b010,
      MODE_BUSOFF = 3'b100
   } mode_t;

endpackage

// File: hdl/can_error_confinement.sv
// Purpose: CAN error detection, counters and error-state confinement
// Assumes: engine on pclk gives one bit_tick per sampled bit with field code
// Notes: APB slave with one wait state; no interrupt logic
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - receiver checks CRC, error frame on mismatch
// - transmitter: recessive ack slot means ack error
// - dominant in delimiters, EOF, IFS: form error
// - transmitter flags bit error on level mismatch
// - no bit error: recessive lost in arbitration/ack
// - six equal bits before CRC delimiter: stuff error
// - own transmission error aborts and requests resend
// - error-active sends dominant error frames
// - error-passive sends recessive error frames
// - bus-off neither transmits nor receives
// - both counts below 128: error-active
// - either count 128 or more: error-passive
// - transmit count 256 or more: bus-off
// - 128 runs of 11 recessive bits recover
// - standard count steps, both counts host readable
// - warning while either count at least 96
// - error mode readable in error flag register
// - flag layout bus-off down to combined warning
// - bus-off flag set at 256, cleared on recovery
module can_error_confinement (
   input wire logic pclk,
   input wire logic presetn,
   input wire can_err_pkg::addr_t paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bit_tick,
   input wire logic rx_bit,
   input wire logic tx_bit,
   input wire logic transmitting,
   input wire can_err_pkg::field_t field,
   input wire logic stuff_bit,
   input wire logic frame_ok,
   output logic err_frame_req,
   output logic err_frame_dominant,
   output logic retx_req,
   output logic tx_allow,
   output logic rx_allow
);
   import can_err_pkg::*;

   typedef struct packed {
      logic [8:0] transmit_error_count;
      logic [7:0] receive_error_count;
      mode_t mode;
      logic [2:0] run_len;
      logic last_bit;
      logic [14:0] crc;
      logic [3:0] rec_run;
      logic [7:0] occ;
      logic [2:0] err_code;
      logic auto_rec;
      logic err_frame_req;
      logic err_frame_dominant;
      logic retx_req;
      logic tx_allow;
      logic rx_allow;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // ***************************************
   // register decode
   // ***************************************
   function automatic logic is_mapped(input addr_t a);
      is_mapped = (a == TX_ERR_COUNT_ADDR) || (a == RX_ERR_COUNT_ADDR) ||
         (a == ERR_FLAG_ADDR) || (a == LAST_ERR_ADDR) || (a == CTRL_ADDR);
   endfunction

   function automatic logic [5:0] flags(input state_t st);
      logic txp;
      logic rxp;
      logic txw;
      logic rxw;
      txp = st.transmit_error_count >= PASSIVE_LIMIT;
      rxp = {1'b0, st.receive_error_count} >= PASSIVE_LIMIT;
      txw = st.transmit_error_count >= WARN_LIMIT;
      rxw = {1'b0, st.receive_error_count} >= WARN_LIMIT;
      flags = {st.mode == MODE_BUSOFF, txp, rxp, txw, rxw, txw | rxw};
   endfunction

   function automatic logic [31:0] read_reg(input addr_t a, input state_t st);
      read_reg = 32'h0000_0000;
      case (a)
         // saturates so the eight-bit view reads 255 once bus-off
         TX_ERR_COUNT_ADDR: read_reg[7:0] = st.transmit_error_count[8] ? 8'hff : st.transmit_error_count[7:0];
         RX_ERR_COUNT_ADDR: read_reg[7:0] = st.receive_error_count;
         ERR_FLAG_ADDR: read_reg[5:0] = flags(st);
         LAST_ERR_ADDR: read_reg[2:0] = st.err_code;
         CTRL_ADDR: read_reg[CTRL_AUTO_REC_BIT] = st.auto_rec;
         default: read_reg = 32'h0000_0000;
      endcase
   endfunction

   // ***************************************
   // error detection
   // ***************************************
   logic live_bit;
   logic stuff_zone;
   logic same_bit;
   logic crc_fb;
   logic [14:0] crc_step;
   logic crc_err;
   logic ack_err;
   logic form_err;
   logic bit_err;
   logic stuff_err;
   logic any_err;
   logic [2:0] code;
   logic [5:0] flag_view;

   assign flag_view = flags(s_reg);
   assign live_bit = bit_tick && (s_reg.mode != MODE_BUSOFF);
   assign stuff_zone = (field == F_SOF) || (field == F_ARB) || (field == F_CTRL) ||
      (field == F_DATA) || (field == F_CRC);
   assign same_bit = rx_bit == s_reg.last_bit;
   assign crc_fb = rx_bit ^ s_reg.crc[14];
   assign crc_step = {s_reg.crc[13:0], 1'b0} ^ (crc_fb ? CRC_POLY : 15'h0000);
   // remainder over data plus received sequence is zero when intact
   assign crc_err = !transmitting && (field == F_CRC_DELIM) && (s_reg.crc != 15'h0000);
   assign ack_err = transmitting && (field == F_ACK_SLOT) && rx_bit;
   assign form_err = !rx_bit && ((field == F_CRC_DELIM) || (field == F_ACK_DELIM) ||
      (field == F_EOF) || (field == F_IFS));
   assign bit_err = transmitting && (field != F_IDLE) && (field != F_IFS) &&
      (field != F_ERR_FRAME) && (rx_bit != tx_bit) &&
      !(tx_bit && !rx_bit && ((field == F_ARB) || (field == F_ACK_SLOT)));
   assign stuff_err = stuff_zone && (field != F_SOF) && same_bit &&
      (s_reg.run_len == STUFF_RUN - 3'h1);
   assign any_err = live_bit && (crc_err || ack_err || form_err || bit_err || stuff_err);

   always_comb begin
      if (bit_err) begin
         code = ERR_BIT;
      end else if (stuff_err) begin
         code = ERR_STUFF;
      end else if (crc_err) begin
         code = ERR_CRC;
      end else if (form_err) begin
         code = ERR_FORM;
      end else begin
         code = ERR_ACK;
      end
   end

   // ***************************************
   // next state
   // ***************************************
   always_comb begin
      s_next = s_reg;
      s_next.err_frame_req = 1'b0;
      s_next.retx_req = 1'b0;
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;

      if (bit_tick) begin
         s_next.last_bit = rx_bit;
         if (field == F_SOF) begin
            s_next.run_len = 3'h1;
         end else if (same_bit && s_reg.run_len != STUFF_RUN) begin
            s_next.run_len = s_reg.run_len + 3'h1;
         end else if (!same_bit) begin
            s_next.run_len = 3'h1;
         end
         // stuff bits are left out of the checksum
         if (field == F_SOF) begin
            s_next.crc = 15'h0000;
         end else if (stuff_zone && !stuff_bit) begin
            s_next.crc = crc_step;
         end
      end

      if (any_err) begin
         s_next.err_code = code;
         s_next.err_frame_req = 1'b1;
         s_next.err_frame_dominant = s_reg.mode == MODE_ACTIVE;
         if (transmitting) begin
            s_next.retx_req = 1'b1;
            s_next.transmit_error_count = s_reg.transmit_error_count + TX_ERR_STEP;
         end else if (s_reg.receive_error_count != 8'hff) begin
            s_next.receive_error_count = s_reg.receive_error_count + 8'h01;
         end
      end else if (frame_ok && s_reg.mode != MODE_BUSOFF) begin
         if (transmitting) begin
            if (s_reg.transmit_error_count != 9'h000) begin
               s_next.transmit_error_count = s_reg.transmit_error_count - 9'h001;
            end
         end else if ({1'b0, s_reg.receive_error_count} >= PASSIVE_LIMIT) begin
            s_next.receive_error_count = RX_RESTORE;
         end else if (s_reg.receive_error_count != 8'h00) begin
            s_next.receive_error_count = s_reg.receive_error_count - 8'h01;
         end
      end

      if (s_reg.mode == MODE_BUSOFF) begin
         if (bit_tick) begin
            if (!rx_bit) begin
               s_next.rec_run = 4'h0;
            end else if (s_reg.rec_run == RECESSIVE_RUN - 4'h1) begin
               s_next.rec_run = 4'h0;
               if (s_reg.occ != RECOVERY_OCCUR) begin
                  s_next.occ = s_reg.occ + 8'h01;
               end
            end else begin
               s_next.rec_run = s_reg.rec_run + 4'h1;
            end
         end
         // without auto recovery the count waits, full, for the host
         if (s_reg.occ == RECOVERY_OCCUR && s_reg.auto_rec) begin
            s_next.transmit_error_count = 9'h000;
            s_next.receive_error_count = 8'h00;
            s_next.occ = 8'h00;
            s_next.mode = MODE_ACTIVE;
         end
      end else if (s_next.transmit_error_count >= BUSOFF_LIMIT) begin
         s_next.mode = MODE_BUSOFF;
         s_next.rec_run = 4'h0;
         s_next.occ = 8'h00;
      end else if (s_next.transmit_error_count >= PASSIVE_LIMIT || {1'b0, s_next.receive_error_count} >= PASSIVE_LIMIT) begin
         s_next.mode = MODE_PASSIVE;
      end else begin
         s_next.mode = MODE_ACTIVE;
      end
      s_next.tx_allow = s_next.mode != MODE_BUSOFF;
      s_next.rx_allow = s_next.mode != MODE_BUSOFF;

      // ***************************************
      // APB: one wait state, write at the completing edge
      // ***************************************
      if (psel && penable && !s_reg.pready) begin
         s_next.pready = 1'b1;
         s_next.pslverr = !is_mapped(paddr);
         s_next.prdata = pwrite ? 32'h0000_0000 : read_reg(paddr, s_reg);
      end
      if (psel && penable && s_reg.pready && pwrite && paddr == CTRL_ADDR) begin
         s_next.auto_rec = pwdata[CTRL_AUTO_REC_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.mode <= MODE_ACTIVE;
         s_reg.auto_rec <= CTRL_AUTO_REC_RST;
         s_reg.tx_allow <= 1'b1;
         s_reg.rx_allow <= 1'b1;
         s_reg.err_frame_dominant <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign err_frame_req = s_reg.err_frame_req;
   assign err_frame_dominant = s_reg.err_frame_dominant;
   assign retx_req = s_reg.retx_req;
   assign tx_allow = s_reg.tx_allow;
   assign rx_allow = s_reg.rx_allow;

   // ***************************************
   // assertions
   // ***************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_ACTIVE: assert property (s_reg.transmit_error_count < PASSIVE_LIMIT && {1'b0, s_reg.receive_error_count} < PASSIVE_LIMIT
      && s_reg.mode != MODE_BUSOFF |-> s_reg.mode == MODE_ACTIVE)
      else $error("active state not taken");
   AST_PASSIVE: assert property (s_reg.mode != MODE_BUSOFF && (s_reg.transmit_error_count >= PASSIVE_LIMIT ||
      {1'b0, s_reg.receive_error_count} >= PASSIVE_LIMIT) |-> s_reg.mode == MODE_PASSIVE)
      else $error("passive state not taken");
   AST_BUSOFF: assert property (s_reg.transmit_error_count >= BUSOFF_LIMIT |-> s_reg.mode == MODE_BUSOFF)
      else $error("bus-off not entered");
   // the error that drives the node off the bus still gets its frame
   AST_QUIET: assert property (s_reg.mode == MODE_BUSOFF |-> !tx_allow && !rx_allow
      && (!err_frame_req || $past(s_reg.mode) != MODE_BUSOFF))
      else $error("bus-off node still active");
   AST_ACK: assert property (bit_tick && transmitting && field == F_ACK_SLOT && rx_bit &&
      s_reg.mode != MODE_BUSOFF |=> err_frame_req && retx_req)
      else $error("ack error missed");
   AST_FORM: assert property (bit_tick && field == F_EOF && !rx_bit && !transmitting &&
      s_reg.mode != MODE_BUSOFF |=> err_frame_req && s_reg.err_code == ERR_FORM)
      else $error("form error missed");
   AST_ARB_LOSS: assert property (bit_tick && field == F_ARB && tx_bit && !rx_bit |=>
      s_reg.err_code != ERR_BIT || !err_frame_req)
      else $error("bit error during arbitration");
   AST_TX_STEP: assert property (any_err && transmitting |=>
      s_reg.transmit_error_count == $past(s_reg.transmit_error_count) + TX_ERR_STEP)
      else $error("transmit count step wrong");
   AST_KIND: assert property (err_frame_req |-> err_frame_dominant == ($past(s_reg.mode) ==
      MODE_ACTIVE))
      else $error("error frame kind wrong");
   AST_WARN: assert property (flag_view[0] == (s_reg.transmit_error_count >= WARN_LIMIT ||
      {1'b0, s_reg.receive_error_count} >= WARN_LIMIT))
      else $error("warning flag wrong");
   AST_RECOVER: assert property (s_reg.mode == MODE_BUSOFF && s_reg.occ == RECOVERY_OCCUR &&
      s_reg.auto_rec |=> s_reg.mode == MODE_ACTIVE && s_reg.transmit_error_count == 9'h000)
      else $error("bus-off recovery missed");
   AST_APB: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");

   COV_BUSOFF: cover property (s_reg.mode == MODE_PASSIVE ##1 s_reg.mode == MODE_BUSOFF);
   COV_RECOVER: cover property (s_reg.mode == MODE_BUSOFF ##1 s_reg.mode == MODE_ACTIVE);
   COV_STUFF: cover property (any_err && stuff_err);
   COV_CRC: cover property (any_err && crc_err);

endmodule

`default_nettype wire

// File: sim/can_bus_nodes.sv
// Purpose: other nodes on the shared CAN bus, seen as one wired-AND bus level
// Assumes: 1 = recessive, 0 = dominant; other nodes drive through other_tx
// Notes: idle bus rests recessive through termination
`timescale 1ns/1ps
`default_nettype none
module can_bus_nodes (
   input wire logic node_tx,
   input wire logic other_tx,
   output logic bus_level
);
   // ***************************************
   // wired-AND bus
   // ***************************************
   // dominant from anyone overwrites recessive, so arbitration and ack work
   assign bus_level = node_tx & other_tx;
endmodule
`default_nettype wire

// File: sim/tb_can_error_confinement.sv
// Purpose: bench for can_error_confinement over APB and bus bit ticks
// Assumes: one wait state APB slave, engine ticks produced by tasks
// Notes: error pulses counted by a monitor, checks compare running totals
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_can_error_confinement;
   import can_err_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   addr_t paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rx_bit, err_frame_req, err_frame_dominant;
   logic retx_req, tx_allow, rx_allow;
   logic bit_tick = 1'b0;
   logic tx_bit = 1'b1;
   logic other_tx = 1'b1;
   logic transmitting = 1'b0;
   logic frame_ok = 1'b0;
   field_t field = F_IDLE;
   int fails = 0;
   int tests_run = 0;
   int n_err = 0;
   int n_retx = 0;
   logic last_dom;
   logic resp_err;
   logic [31:0] rd;

   always #2.5 pclk = ~pclk;

   can_error_confinement u_can_error_confinement (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bit_tick(bit_tick), .rx_bit(rx_bit), .tx_bit(tx_bit),
      .transmitting(transmitting), .field(field), .stuff_bit(1'b0), .frame_ok(frame_ok),
      .err_frame_req(err_frame_req), .err_frame_dominant(err_frame_dominant),
      .retx_req(retx_req), .tx_allow(tx_allow), .rx_allow(rx_allow));
   can_bus_nodes u_can_bus_nodes (.node_tx(tx_bit), .other_tx(other_tx), .bus_level(rx_bit));

   always @(posedge pclk) begin
      if (err_frame_req === 1'b1) begin
         n_err++;
         last_dom = err_frame_dominant;
      end
      if (retx_req === 1'b1)
         n_retx++;
   end

   // ***************************************
   // access tasks
   // ***************************************
   task automatic apb(input logic w, input addr_t a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) begin
         fails++;
         finish_test;
      end
      rd = prdata;
      resp_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input addr_t a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask

   // one sampled bus bit; node drives tx, other nodes drive oth
   task automatic bt(input field_t f, input logic xm, input logic tx, input logic oth);
      @(posedge pclk);
      bit_tick <= 1'b1;
      field <= f;
      transmitting <= xm;
      tx_bit <= tx;
      other_tx <= oth;
      @(posedge pclk);
      bit_tick <= 1'b0;
      tx_bit <= 1'b1;
      other_tx <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   task automatic fok(input logic xm);
      @(posedge pclk);
      frame_ok <= 1'b1;
      transmitting <= xm;
      @(posedge pclk);
      frame_ok <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   task automatic rst;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task finish_test;
      $display("counts: fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ***************************************
   // tests
   // ***************************************
   initial begin
      #200000;
      fails++;
      finish_test;
   end

   initial begin
      rst;
      rchk(TX_ERR_COUNT_ADDR, 32'h0);
      rchk(RX_ERR_COUNT_ADDR, 32'h0);
      rchk(ERR_FLAG_ADDR, 32'h0);
      rchk(CTRL_ADDR, 32'h1);
      apb(1'b1, CTRL_ADDR, 32'h0);
      rchk(CTRL_ADDR, 32'h0);
      apb(1'b1, CTRL_ADDR, 32'h1);
      rchk(CTRL_ADDR, 32'h1);
      apb(1'b1, TX_ERR_COUNT_ADDR, 32'hff);
      rchk(TX_ERR_COUNT_ADDR, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      `CHK(resp_err, 1'b1)
      `CHK(rd, 32'h0)
      // receiver: five dominant bits pass, the sixth is a stuff error
      bt(F_SOF, 1'b0, 1'b1, 1'b0);
      repeat (4) bt(F_ARB, 1'b0, 1'b1, 1'b0);
      `CHK(n_err, 0)
      bt(F_ARB, 1'b0, 1'b1, 1'b0);
      `CHK(n_err, 1)
      rchk(LAST_ERR_ADDR, {29'h0, ERR_STUFF});
      bt(F_EOF, 1'b0, 1'b1, 1'b0);
      rchk(LAST_ERR_ADDR, {29'h0, ERR_FORM});
      bt(F_SOF, 1'b0, 1'b1, 1'b0);
      bt(F_DATA, 1'b0, 1'b1, 1'b1);
      bt(F_CRC_DELIM, 1'b0, 1'b1, 1'b1);
      rchk(LAST_ERR_ADDR, {29'h0, ERR_CRC});
      rchk(RX_ERR_COUNT_ADDR, 32'h3);
      fok(1'b0);
      rchk(RX_ERR_COUNT_ADDR, 32'h2);
      // transmitter: lost arbitration and ack are not bit errors
      bt(F_SOF, 1'b1, 1'b0, 1'b1);
      bt(F_ARB, 1'b1, 1'b1, 1'b0);
      bt(F_ACK_SLOT, 1'b1, 1'b1, 1'b0);
      `CHK(n_err, 3)
      bt(F_DATA, 1'b1, 1'b1, 1'b0);
      rchk(LAST_ERR_ADDR, {29'h0, ERR_BIT});
      `CHK(n_retx, 1)
      rchk(TX_ERR_COUNT_ADDR, 32'h8);
      fok(1'b1);
      rchk(TX_ERR_COUNT_ADDR, 32'h7);
      // second reset, then ack errors all the way to bus-off
      rst;
      n_err = 0;
      n_retx = 0;
      rchk(TX_ERR_COUNT_ADDR, 32'h0);
      for (int i = 1; i <= 32; i++) begin
         bt(F_ACK_SLOT, 1'b1, 1'b1, 1'b1);
         if (i == 11) rchk(ERR_FLAG_ADDR, 32'h0);
         if (i == 12) rchk(ERR_FLAG_ADDR, 32'h5);
         if (i == 16) `CHK(last_dom, 1'b1)
         if (i == 17) `CHK(last_dom, 1'b0)
         if (i == 17) rchk(ERR_FLAG_ADDR, 32'h15);
         if (i == 31) `CHK(tx_allow, 1'b1)
      end
      `CHK(n_err, 32)
      `CHK(n_retx, 32)
      `CHK(tx_allow, 1'b0)
      `CHK(rx_allow, 1'b0)
      rchk(ERR_FLAG_ADDR, 32'h35);
      rchk(TX_ERR_COUNT_ADDR, 32'hff);
      bt(F_DATA, 1'b1, 1'b1, 1'b0);
      `CHK(n_err, 32)
      // recovery needs exactly 128 runs of 11 recessive bits
      repeat (1407) bt(F_IDLE, 1'b0, 1'b1, 1'b1);
      `CHK(tx_allow, 1'b0)
      bt(F_IDLE, 1'b0, 1'b1, 1'b1);
      repeat (2) @(posedge pclk);
      `CHK(tx_allow, 1'b1)
      rchk(ERR_FLAG_ADDR, 32'h0);
      rchk(TX_ERR_COUNT_ADDR, 32'h0);
      finish_test;
   end
endmodule
`default_nettype wire
